// *** hw/tlr_ctrl_map.svh ***
// Register offsets, field positions, reset values and timing constants for the
// temperature look-up resistor controller. Assumes a 125 MHz system clock.
`ifndef TLR_CTRL_MAP_SVH
`define TLR_CTRL_MAP_SVH

// Memory pages seen by the 2-wire engine
`define TLR_PAGE_MAIN 2'h0
`define TLR_PAGE_T01 2'h1
`define TLR_PAGE_T02 2'h2
`define TLR_PAGE_T03 2'h3

// Main device page offsets
`define TLR_OFS_TEMP_MSB 8'h60
`define TLR_OFS_TEMP_LSB 8'h61
`define TLR_OFS_STATUS 8'h6E
`define TLR_OFS_ALARM 8'h70
`define TLR_BIT_NOT_READY 0
`define TLR_BIT_SUPPLY_LOW 4

// Table 01 offsets
`define TLR_OFS_MODE 8'h80
`define TLR_OFS_INDEX 8'h81
`define TLR_OFS_MAN0 8'h82
`define TLR_OFS_MAN1 8'h83
`define TLR_OFS_CONFIG 8'h89
`define TLR_OFS_MAIN_ADDR 8'h8C

// Field positions
`define TLR_BIT_TEMP_CTRL_EN 1
`define TLR_BIT_AUTO_INDEX_EN 0
`define TLR_BIT_DUAL_ADDR 5
`define TLR_BIT_ADDR_SRC 4
`define TLR_BIT_AUX_PROT 3
`define TLR_BIT_MAIN_PROT 2

// Reset values
`define TLR_RST_MODE 8'h03
`define TLR_RST_CONFIG 8'h00
`define TLR_RST_MAIN_ADDR 8'hA2
`define TLR_RST_LUT 8'hFF
`define TLR_AUX_ADDR 8'hA0
`define TLR_PIN_ADDR_HI 4'hA

// Look-up table layout: 72 entries from 80h to C7h
`define TLR_LUT_BASE 8'h80
`define TLR_LUT_LAST 8'hC7
`define TLR_LUT_ENTRIES 72

// Sensor scale in millivolts: 500 mV at 0 C, 10 mV per C, -40 C lower end
`define TLR_MV_OFFSET 500
`define TLR_MV_PER_C 10
`define TLR_T_MIN_C 40
`define TLR_STEP_C 2
`define TLR_HYST_C 1

// Timing
`define TLR_CLK_MHZ 125
`define TLR_READY_DELAY_NS 2000
`define TLR_FRAME_US 200

`endif

// *** hw/tlr_ctrl_pkg.sv ***
// Types shared by the temperature look-up resistor controller.
// Assumes the constants of tlr_ctrl_map.svh.
package tlr_ctrl_pkg;

  // Power sequencing states, one-hot
  typedef enum logic [2:0] {
    TLR_PWR_WAIT = 3'h1,
    TLR_PWR_DELAY = 3'h2,
    TLR_PWR_RUN = 3'h4
  } tlr_pwr_t;

  // State of the controller apart from the look-up tables
  typedef struct packed {
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;
    logic aok_s1;
    logic aok_s2;
    tlr_pwr_t pwr;
    logic [15:0] dly_cnt;
    logic [23:0] frame_cnt;
    logic recall_done;
    logic not_ready;
    logic [7:0] nv_config;
    logic [7:0] nv_addr;
    logic [7:0] config_sh;
    logic [7:0] addr_sh;
    logic [7:0] mode;
    logic [6:0] index;
    logic [7:0] man0;
    logic [7:0] man1;
    logic [11:0] temp_mv;
    logic supply_low;
    logic conv_pend;
    logic conv_busy;
    logic conv_start;
    logic [7:0] rdata;
    logic [7:0] res0;
    logic [7:0] res1;
  } tlr_state_t;

endpackage

// *** hw/tlr_ctrl.sv ***
// Temperature-indexed look-up control of two resistor settings, with address
// and protection configuration and power-up sequencing.
// Assumes a 2-wire engine on the same clock presents byte reads and writes,
// an on-chip converter delivers sensor millivolts, and sys_rst_i is the digital
// power-on reset.
// How it works
// - config bit 5 selects one or two addresses
// - config bit 4 selects pin or stored address
// - config bits 3,2 are write-protect controls
// - byte 8Ch, default A2, gives stored address
// - resistor 0 table at 80-C7, default FF
// - resistor 1 table at 80-C7, default FF
// - sensor is 500 mV plus 10 mV per degree
// - index spans minus 40 to 102 degrees
// - index advances once per 2 degree step
// - one degree hysteresis at each step boundary
// - conversions from power-up, result at 60h/61h
// - no conversion while host access in progress
// - inactive until digital threshold is passed
// - recall only after analog threshold is passed
// - not-ready at 6Eh clears after timed delay
// - not-ready returns high when analog supply drops
// - recalled values hold until digital reset
// - pin address used until recall completes
// - auxiliary A0h answers until recall completes
// - supply-low alarm reads 1 until first conversion
// - manual positions 82h/83h when control disabled
// - host writes index when auto index disabled
// - index readable at 81h, selects table entry
`timescale 1ns/100ps
`include "tlr_ctrl_map.svh"

module tlr_ctrl #(
  parameter int FRAME_CYCLES = `TLR_FRAME_US * `TLR_CLK_MHZ,
  parameter int LUT_ENTRIES = `TLR_LUT_ENTRIES
) (
  // Clock and digital power-on reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Pins and supply monitor
  input wire logic [2:0] addr_pins_i,
  input wire logic analog_power_ok_i,
  // Converter
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_mv_i,
  input wire logic supply_conv_done_i,
  input wire logic supply_low_i,
  // Memory port from the 2-wire engine
  input wire logic host_busy_i,
  input wire logic [1:0] mem_page_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o,
  // Addressing and protection
  output logic [7:0] main_addr_o,
  output logic aux_addr_en_o,
  output logic aux_protect_enable_o,
  output logic main_protect_enable_o,
  // Resistor positions
  output logic [7:0] res0_pos_o,
  output logic [7:0] res1_pos_o,
  output logic not_ready_flag_o
);

  // Timing counts derived from the clock rate
  localparam int READY_CYCLES_RAW = (`TLR_READY_DELAY_NS * `TLR_CLK_MHZ + 999) / 1000;
  localparam int READY_CYCLES = (READY_CYCLES_RAW < 1) ? 1 : READY_CYCLES_RAW;
  localparam logic [15:0] READY_LAST = 16'(READY_CYCLES - 1);
  localparam logic [23:0] FRAME_LAST = 24'(FRAME_CYCLES - 1);
  localparam logic [6:0] IDX_LAST = 7'(LUT_ENTRIES - 1);
  // Millivolts at the lower end of entry 0, and per step and per hysteresis
  localparam logic [12:0] MV_BASE = 13'(`TLR_MV_OFFSET - `TLR_T_MIN_C * `TLR_MV_PER_C);
  localparam logic [12:0] MV_STEP = 13'(`TLR_STEP_C * `TLR_MV_PER_C);
  localparam logic [12:0] MV_HYST = 13'(`TLR_HYST_C * `TLR_MV_PER_C);

  tlr_ctrl_pkg::tlr_state_t q;
  tlr_ctrl_pkg::tlr_state_t d;

  // Look-up tables for resistor 0 and 1
  logic [7:0] lut0 [LUT_ENTRIES];
  logic [7:0] lut1 [LUT_ENTRIES];

  logic [7:0] lut_rd_idx;
  logic lut_hit;
  logic lut0_we;
  logic lut1_we;
  logic [12:0] thr_up;
  logic [12:0] thr_down;
  logic [12:0] v_now;
  logic [7:0] pin_addr;
  logic [7:0] wr_addr;
  logic conv_go;

  // Host table access decode
  assign lut_hit = (mem_addr_i >= `TLR_LUT_BASE) && (mem_addr_i <= `TLR_LUT_LAST);
  assign lut_rd_idx = mem_addr_i - `TLR_LUT_BASE;
  assign lut0_we = mem_wr_i && lut_hit && (mem_page_i == `TLR_PAGE_T02);
  assign lut1_we = mem_wr_i && lut_hit && (mem_page_i == `TLR_PAGE_T03);

  // Step boundaries around the current index, in sensor millivolts
  assign v_now = {1'b0, q.temp_mv};
  assign thr_up = MV_BASE + 13'(MV_STEP * 13'({6'h00, q.index} + 13'h0001));
  assign thr_down = MV_BASE + 13'(MV_STEP * 13'({6'h00, q.index})) - MV_HYST;

  // Address from the pins
  assign pin_addr = {`TLR_PIN_ADDR_HI, q.pins_s2, 1'b0};
  assign conv_go = q.conv_pend && !host_busy_i && !q.conv_busy && (q.pwr == tlr_ctrl_pkg::TLR_PWR_RUN);

  // Next-state logic
  always_comb
  begin
    d = q;
    d.conv_start = 1'b0;
    d.pins_s1 = addr_pins_i;
    d.pins_s2 = q.pins_s1;
    d.aok_s1 = analog_power_ok_i;
    d.aok_s2 = q.aok_s1;
    wr_addr = mem_addr_i;

    // Power sequencing and recall
    case (q.pwr)
      tlr_ctrl_pkg::TLR_PWR_WAIT:
      begin
        d.not_ready = 1'b1;
        if (q.aok_s2)
        begin
          if (!q.recall_done)
          begin
            d.config_sh = q.nv_config;
            d.addr_sh = q.nv_addr;
            d.recall_done = 1'b1;
          end
          d.dly_cnt = 16'h0000;
          d.pwr = tlr_ctrl_pkg::TLR_PWR_DELAY;
        end
      end
      tlr_ctrl_pkg::TLR_PWR_DELAY:
      begin
        if (!q.aok_s2)
        begin
          d.pwr = tlr_ctrl_pkg::TLR_PWR_WAIT;
        end
        else if (q.dly_cnt == READY_LAST)
        begin
          d.not_ready = 1'b0;
          d.pwr = tlr_ctrl_pkg::TLR_PWR_RUN;
          d.conv_pend = 1'b1;
        end
        else
        begin
          d.dly_cnt = q.dly_cnt + 16'h0001;
        end
      end
      tlr_ctrl_pkg::TLR_PWR_RUN:
      begin
        if (!q.aok_s2)
        begin
          d.not_ready = 1'b1;
          d.pwr = tlr_ctrl_pkg::TLR_PWR_WAIT;
        end
      end
      default:
      begin
        d.pwr = tlr_ctrl_pkg::TLR_PWR_WAIT;
      end
    endcase

    // Frame timer requests one conversion per frame
    if (q.frame_cnt == FRAME_LAST)
    begin
      d.frame_cnt = 24'h000000;
      if (q.pwr == tlr_ctrl_pkg::TLR_PWR_RUN)
      begin
        d.conv_pend = 1'b1;
      end
    end
    else
    begin
      d.frame_cnt = q.frame_cnt + 24'h000001;
    end

    // Start a pending conversion only while the host is idle
    if (conv_go)
    begin
      d.conv_pend = (q.frame_cnt == FRAME_LAST); // A frame wrap in this cycle stays pending
      d.conv_busy = 1'b1;
      d.conv_start = 1'b1;
    end
    if (conv_done_i && q.conv_busy)
    begin
      d.conv_busy = 1'b0;
      d.temp_mv = conv_mv_i;
    end
    if (d.pwr != tlr_ctrl_pkg::TLR_PWR_RUN) // keeps the request raised on entry to run
    begin
      d.conv_pend = 1'b0;
      d.conv_busy = 1'b0;
    end

    // Supply-low alarm follows each supply conversion
    if (supply_conv_done_i)
    begin
      d.supply_low = supply_low_i;
    end

    // Index tracking, one step per cycle with hysteresis
    if (q.mode[`TLR_BIT_AUTO_INDEX_EN] && (q.pwr == tlr_ctrl_pkg::TLR_PWR_RUN))
    begin
      if ((v_now >= thr_up) && (q.index < IDX_LAST))
      begin
        d.index = q.index + 7'h01;
      end
      else if ((v_now < thr_down) && (q.index != 7'h00))
      begin
        d.index = q.index - 7'h01;
      end
    end

    // Host writes
    if (mem_wr_i && (mem_page_i == `TLR_PAGE_T01))
    begin
      case (wr_addr)
        `TLR_OFS_MODE:
        begin
          d.mode = mem_wdata_i;
        end
        `TLR_OFS_INDEX:
        begin
          if (!q.mode[`TLR_BIT_AUTO_INDEX_EN])
          begin
            d.index = (mem_wdata_i[6:0] > IDX_LAST || mem_wdata_i[7]) ? IDX_LAST : mem_wdata_i[6:0];
          end
        end
        `TLR_OFS_MAN0:
        begin
          d.man0 = mem_wdata_i;
        end
        `TLR_OFS_MAN1:
        begin
          d.man1 = mem_wdata_i;
        end
        `TLR_OFS_CONFIG:
        begin
          d.nv_config = {2'b00, mem_wdata_i[5:2], 2'b00};
          d.config_sh = {2'b00, mem_wdata_i[5:2], 2'b00};
        end
        `TLR_OFS_MAIN_ADDR:
        begin
          d.nv_addr = mem_wdata_i;
          d.addr_sh = mem_wdata_i;
        end
        default:
        begin
          d.nv_addr = d.nv_addr;
        end
      endcase
    end

    // Host reads, data returned one cycle later
    if (mem_rd_i)
    begin
      d.rdata = 8'h00;
      case (mem_page_i)
        `TLR_PAGE_MAIN:
        begin
          if (mem_addr_i == `TLR_OFS_TEMP_MSB)
          begin
            d.rdata = {4'h0, q.temp_mv[11:8]};
          end
          else if (mem_addr_i == `TLR_OFS_TEMP_LSB)
          begin
            d.rdata = q.temp_mv[7:0];
          end
          else if (mem_addr_i == `TLR_OFS_STATUS)
          begin
            d.rdata[`TLR_BIT_NOT_READY] = q.not_ready;
          end
          else if (mem_addr_i == `TLR_OFS_ALARM)
          begin
            d.rdata[`TLR_BIT_SUPPLY_LOW] = q.supply_low;
          end
        end
        `TLR_PAGE_T01:
        begin
          if (mem_addr_i == `TLR_OFS_MODE)
          begin
            d.rdata = q.mode;
          end
          else if (mem_addr_i == `TLR_OFS_INDEX)
          begin
            d.rdata = {1'b0, q.index};
          end
          else if (mem_addr_i == `TLR_OFS_MAN0)
          begin
            d.rdata = q.man0;
          end
          else if (mem_addr_i == `TLR_OFS_MAN1)
          begin
            d.rdata = q.man1;
          end
          else if (mem_addr_i == `TLR_OFS_CONFIG)
          begin
            d.rdata = q.nv_config;
          end
          else if (mem_addr_i == `TLR_OFS_MAIN_ADDR)
          begin
            d.rdata = q.nv_addr;
          end
        end
        `TLR_PAGE_T02:
        begin
          d.rdata = lut_hit ? lut0[lut_rd_idx[6:0]] : `TLR_RST_LUT;
        end
        `TLR_PAGE_T03:
        begin
          d.rdata = lut_hit ? lut1[lut_rd_idx[6:0]] : `TLR_RST_LUT;
        end
        default:
        begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Resistor positions: table entry or manual setting
    if (q.mode[`TLR_BIT_TEMP_CTRL_EN])
    begin
      d.res0 = lut0[q.index];
      d.res1 = lut1[q.index];
    end
    else
    begin
      d.res0 = q.man0;
      d.res1 = q.man1;
    end
  end

  // State register; reset is the digital power-on threshold
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.pwr <= tlr_ctrl_pkg::TLR_PWR_WAIT;
      q.not_ready <= 1'b1;
      q.nv_config <= `TLR_RST_CONFIG;
      q.nv_addr <= `TLR_RST_MAIN_ADDR;
      q.config_sh <= `TLR_RST_CONFIG;
      q.addr_sh <= `TLR_RST_MAIN_ADDR;
      q.mode <= `TLR_RST_MODE;
      q.supply_low <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Table storage, host written
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < LUT_ENTRIES; i++)
      begin
        lut0[i] <= `TLR_RST_LUT;
        lut1[i] <= `TLR_RST_LUT;
      end
    end
    else
    begin
      if (lut0_we)
      begin
        lut0[lut_rd_idx[6:0]] <= mem_wdata_i;
      end
      if (lut1_we)
      begin
        lut1[lut_rd_idx[6:0]] <= mem_wdata_i;
      end
    end
  end

  // Addressing outputs: pins and auxiliary until recall completes
  assign main_addr_o = (q.config_sh[`TLR_BIT_ADDR_SRC] && q.recall_done) ? q.addr_sh : pin_addr;
  assign aux_addr_en_o = !q.recall_done || !q.config_sh[`TLR_BIT_DUAL_ADDR];
  assign aux_protect_enable_o = q.config_sh[`TLR_BIT_AUX_PROT];
  assign main_protect_enable_o = q.config_sh[`TLR_BIT_MAIN_PROT];

  // Remaining outputs
  assign conv_start_o = q.conv_start;
  assign mem_rdata_o = q.rdata;
  assign res0_pos_o = q.res0;
  assign res1_pos_o = q.res1;
  assign not_ready_flag_o = q.not_ready;

endmodule

// *** tb/tlr_ctrl_props.sv ***
// Checker for the look-up resistor controller, watching only its top ports.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/100ps
module tlr_ctrl_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Observed ports
  input wire logic analog_power_ok_i,
  input wire logic conv_start_o,
  input wire logic host_busy_i,
  input wire logic [1:0] mem_page_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic [7:0] main_addr_o,
  input wire logic aux_addr_en_o,
  input wire logic aux_protect_enable_o,
  input wire logic main_protect_enable_o,
  input wire logic [7:0] res0_pos_o,
  input wire logic not_ready_flag_o
);
  logic seen_ok_q;
  logic [7:0] mode_q;
  logic [7:0] man0_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Supply history, mode byte and manual position 0 as the host set them
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      seen_ok_q <= 1'b0;
      mode_q <= 8'h03;
      man0_q <= 8'h00;
    end
    else
    begin
      seen_ok_q <= seen_ok_q | analog_power_ok_i;
      if (mem_wr_i && mem_page_i == 2'h1 && mem_addr_i == 8'h80)
        mode_q <= mem_wdata_i;
      if (mem_wr_i && mem_page_i == 2'h1 && mem_addr_i == 8'h82)
        man0_q <= mem_wdata_i;
    end
  end
  // Steps of the sequences
  sequence s_supply_gone;
    !analog_power_ok_i [*4];
  endsequence
  sequence s_cfg_wr;
    mem_wr_i && mem_page_i == 2'h1 && mem_addr_i == 8'h89;
  endsequence
  AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  AST_NO_START_BUSY: assert property (conv_start_o |-> !$past(host_busy_i))
    else $error("conversion started during host access");
  AST_READY_RISE: assert property (s_supply_gone |-> not_ready_flag_o)
    else $error("not ready flag low after supply loss");
  AST_READY_FALL: assert property ($fell(not_ready_flag_o) |-> $past(analog_power_ok_i, 8))
    else $error("ready without analog supply");
  AST_FIRST_CONV: assert property ($fell(not_ready_flag_o) && !host_busy_i |=> conv_start_o)
    else $error("no conversion started when ready");
  AST_RDATA_HOLD: assert property (!mem_rd_i |=> $stable(mem_rdata_o))
    else $error("read data changed without a read");
  AST_PROT_BITS: assert property (s_cfg_wr |=> aux_protect_enable_o == $past(mem_wdata_i[3])
    && main_protect_enable_o == $past(mem_wdata_i[2]))
    else $error("protect outputs differ from config write");
  AST_EARLY_ADDR: assert property (!seen_ok_q |-> aux_addr_en_o && main_addr_o[7:4] == 4'hA
    && !main_addr_o[0])
    else $error("address wrong before recall");
  AST_MANUAL_RES: assert property (!mode_q[1] && !not_ready_flag_o |=> res0_pos_o == $past(man0_q))
    else $error("manual resistor position not applied");
endmodule

bind tlr_ctrl tlr_ctrl_props props_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .analog_power_ok_i(analog_power_ok_i), .conv_start_o(conv_start_o), .host_busy_i(host_busy_i),
  .mem_page_i(mem_page_i), .mem_addr_i(mem_addr_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
  .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o), .main_addr_o(main_addr_o),
  .aux_addr_en_o(aux_addr_en_o), .aux_protect_enable_o(aux_protect_enable_o),
  .main_protect_enable_o(main_protect_enable_o), .res0_pos_o(res0_pos_o),
  .not_ready_flag_o(not_ready_flag_o));

// *** tb/tlr_sensor_model.sv ***
// Sensor and converter stand-in: answers each start with one result.
// Assumes the bench sets the voltage and picks fast or slow answers.
`timescale 1ns/100ps
module tlr_sensor_model (
  // Clock
  input wire logic clock_i,
  // Controls
  input wire logic conv_start_i,
  input wire logic slow_i,
  input wire logic [11:0] mv_i,
  // Result
  output logic conv_done_o = 1'b0,
  output logic [11:0] conv_mv_o = 12'h000
);
  int wait_q = 0;
  // Counts a conversion down; outside the result the data toggles
  always @(posedge clock_i)
  begin
    conv_done_o <= 1'b0;
    conv_mv_o <= ~conv_mv_o;
    if (conv_start_i)
      wait_q <= slow_i ? 20 : 3;
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    if (wait_q == 1 && !conv_start_i)
    begin
      conv_done_o <= 1'b1;
      conv_mv_o <= mv_i;
    end
  end
endmodule

// *** tb/tlr_ctrl_bench.sv ***
// Self-checking bench for the look-up resistor controller.
// Assumes the sensor model and a short frame parameter.
`timescale 1ns/100ps
module tlr_ctrl_bench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] addr_pins_i = 3'h5;
  logic analog_power_ok_i = 1'b0;
  logic host_busy_i = 1'b0;
  logic supply_conv_done_i = 1'b0;
  logic supply_low_i = 1'b1;
  logic slow = 1'b0;
  logic [11:0] mv = 12'h12C;
  logic [1:0] mem_page_i = 2'h0;
  logic [7:0] mem_addr_i = 8'h00;
  logic mem_rd_i = 1'b0;
  logic mem_wr_i = 1'b0;
  logic [7:0] mem_wdata_i = 8'h00;
  logic conv_start_o, conv_done_i, aux_addr_en_o, aux_protect_enable_o, main_protect_enable_o, not_ready_flag_o;
  logic [11:0] conv_mv_i;
  logic [7:0] mem_rdata_o, main_addr_o, res0_pos_o, res1_pos_o, rd_q;
  int n_errors = 0;
  int n_compared = 0;
  int n_cyc = 0;
  int n_start = 0;
  int t;
  // Sweep rows: millivolts, index, resistor 0, resistor 1
  logic [11:0] sw_mv [7] = '{12'h12C, 12'h127, 12'h121, 12'h12B, 12'h12C, 12'hFA0, 12'h000};
  logic [7:0] sw_ix [7] = '{8'h0A, 8'h0A, 8'h09, 8'h09, 8'h0A, 8'h47, 8'h00};
  logic [7:0] sw_r0 [7] = '{8'h5A, 8'h5A, 8'hFF, 8'hFF, 8'h5A, 8'h3C, 8'hFF};
  logic [7:0] sw_r1 [7] = '{8'hA5, 8'hA5, 8'hFF, 8'hFF, 8'hA5, 8'hC3, 8'hFF};

  tlr_ctrl #(.FRAME_CYCLES(50)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_pins_i(addr_pins_i),
    .analog_power_ok_i(analog_power_ok_i), .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
    .conv_mv_i(conv_mv_i), .supply_conv_done_i(supply_conv_done_i), .supply_low_i(supply_low_i),
    .host_busy_i(host_busy_i), .mem_page_i(mem_page_i), .mem_addr_i(mem_addr_i), .mem_rd_i(mem_rd_i),
    .mem_wr_i(mem_wr_i), .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o), .main_addr_o(main_addr_o),
    .aux_addr_en_o(aux_addr_en_o), .aux_protect_enable_o(aux_protect_enable_o),
    .main_protect_enable_o(main_protect_enable_o), .res0_pos_o(res0_pos_o), .res1_pos_o(res1_pos_o),
    .not_ready_flag_o(not_ready_flag_o));
  tlr_sensor_model sensor_u (.clock_i(clock_i), .conv_start_i(conv_start_o), .slow_i(slow), .mv_i(mv),
    .conv_done_o(conv_done_i), .conv_mv_o(conv_mv_i));

  // Clock
  always #4 clock_i = ~clock_i;
  // Cycle watchdog and start counter
  always @(posedge clock_i)
  begin
    n_cyc++;
    if (conv_start_o === 1'b1)
      n_start++;
    if (n_cyc == 8000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One memory access; read data is captured after the taking edge
  task automatic acc(input logic w, input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    mem_page_i = pg;
    mem_addr_i = a;
    mem_wdata_i = d;
    mem_wr_i = w;
    mem_rd_i = !w;
    cyc(1);
    mem_wr_i = 1'b0;
    mem_rd_i = 1'b0;
    rd_q = mem_rdata_o;
  endtask

  task automatic rc(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] exp, input string what);
    acc(1'b0, pg, a, 8'h00);
    chk(what, exp, rd_q);
  endtask

  // Main sequence
  initial
  begin
    cyc(6);
    sys_rst_i = 1'b0;
    cyc(3);
    rc(2'h1, 8'h8C, 8'hA2, "stored address");
    rc(2'h1, 8'h89, 8'h00, "config");
    rc(2'h2, 8'h80, 8'hFF, "table0 first");
    rc(2'h3, 8'hC7, 8'hFF, "table1 last");
    acc(1'b0, 2'h0, 8'h70, 8'h00);
    chk("supply low alarm", 8'h01, {7'h00, rd_q[4]});
    acc(1'b0, 2'h0, 8'h6E, 8'h00);
    chk("not ready bit", 8'h01, {7'h00, rd_q[0]});
    // Stored address, config and table entries before recall
    acc(1'b1, 2'h1, 8'h89, 8'h30);
    acc(1'b1, 2'h1, 8'h8C, 8'hB6);
    acc(1'b1, 2'h2, 8'h8A, 8'h5A);
    acc(1'b1, 2'h3, 8'h8A, 8'hA5);
    acc(1'b1, 2'h2, 8'hC7, 8'h3C);
    acc(1'b1, 2'h3, 8'hC7, 8'hC3);
    chk("early address", 8'hAA, main_addr_o);
    chk("early aux", 8'h01, {7'h00, aux_addr_en_o});
    // Analog supply good: timed ready, then stored address in use
    analog_power_ok_i = 1'b1;
    t = 0;
    while (not_ready_flag_o === 1'b1 && t < 400)
    begin
      cyc(1);
      t++;
    end
    chk("ready delay", 8'h01, {7'h00, t >= 250 && t <= 256});
    chk("main address", 8'hB6, main_addr_o);
    chk("aux enable", 8'h00, {7'h00, aux_addr_en_o});
    // Temperature sweep across boundaries, hysteresis and clamps
    for (int i = 0; i < 7; i++)
    begin
      mv = sw_mv[i];
      slow = i[0];
      cyc(260);
      rc(2'h1, 8'h81, sw_ix[i], "index");
      rc(2'h0, 8'h60, {4'h0, sw_mv[i][11:8]}, "temp high");
      rc(2'h0, 8'h61, sw_mv[i][7:0], "temp low");
      chk("res0", sw_r0[i], res0_pos_o);
      chk("res1", sw_r1[i], res1_pos_o);
    end
    acc(1'b1, 2'h1, 8'h81, 8'h05);
    rc(2'h1, 8'h81, 8'h00, "index locked");
    // No conversion during host access
    host_busy_i = 1'b1;
    cyc(2);
    n_start = 0;
    cyc(150);
    chk("starts while busy", 8'h00, n_start[7:0]);
    host_busy_i = 1'b0;
    cyc(60);
    chk("starts after busy", 8'h01, {7'h00, n_start > 0});
    // First supply conversion clears the alarm
    supply_low_i = 1'b0;
    supply_conv_done_i = 1'b1;
    cyc(1);
    supply_conv_done_i = 1'b0;
    acc(1'b0, 2'h0, 8'h70, 8'h00);
    chk("supply low cleared", 8'h00, {7'h00, rd_q[4]});
    // Manual index, then manual positions
    acc(1'b1, 2'h1, 8'h80, 8'h02);
    acc(1'b1, 2'h1, 8'h81, 8'h0A);
    rc(2'h1, 8'h81, 8'h0A, "manual index");
    cyc(3);
    chk("res0 manual index", 8'h5A, res0_pos_o);
    acc(1'b1, 2'h1, 8'h81, 8'hFF);
    rc(2'h1, 8'h81, 8'h47, "index clamp");
    acc(1'b1, 2'h1, 8'h80, 8'h00);
    acc(1'b1, 2'h1, 8'h82, 8'h11);
    acc(1'b1, 2'h1, 8'h83, 8'h22);
    cyc(3);
    chk("res0 manual", 8'h11, res0_pos_o);
    chk("res1 manual", 8'h22, res1_pos_o);
    // Protection bits and unused config bits
    acc(1'b1, 2'h1, 8'h89, 8'hFF);
    rc(2'h1, 8'h89, 8'h3C, "config kept bits");
    chk("protect", 8'h03, {6'h00, aux_protect_enable_o, main_protect_enable_o});
    // Analog supply dip: not ready again, recalled values kept
    analog_power_ok_i = 1'b0;
    cyc(5);
    chk("not ready after dip", 8'h01, {7'h00, not_ready_flag_o});
    chk("address after dip", 8'hB6, main_addr_o);
    print_verdict();
  end
endmodule
